/* verilog/dpcm_host.sv */
// Host-side controller for one port of a dual-port memory
//
// Operation
// - Host spaces contending accesses by the priority window for determinism.
// - Host holds write strobe the write-hold time after conflict clears.
// - Slave conflict input valid no later than write strobe start.
// - Hosts initialise mailbox flags after power-up by reading mailbox; the controller makes no such read of its own after reset.
// - Host spaces semaphore claims by the contention window.
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module dpcm_host #(
    parameter logic IS_LEFT = 1'b1
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic irq_o,
    // Memory port pins
    output logic [15:0] mem_addr_o,
    output logic chip_enable_n_o,
    output logic rd_wr_n_o,
    output logic output_enable_n_o,
    output logic semaphore_select_n_o,
    output logic upper_lane_select_n_o,
    output logic lower_lane_select_n_o,
    output logic [15:0] mem_data_o,
    output logic mem_data_oe_n_o,
    input wire logic [15:0] mem_data_i,
    // Conflict flag and mailbox irq from the device
    input wire logic conflict_flag_n_i,
    input wire logic mailbox_irq_n_i
);
    // Registers
    dpcm_pkg::dpcm_state_t state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [15:0] addr, next_addr;
    logic [15:0] wdata, next_wdata;
    logic [15:0] rdata, next_rdata;
    logic op_wr, next_op_wr;
    logic op_sem, next_op_sem;
    logic [2:0] irq_stat, next_irq_stat;
    logic [2:0] irq_mask, next_irq_mask;
    logic [31:0] rd_q, next_rd_q;
    logic ack, next_ack;
    logic conflict_seen, next_conflict_seen;
    // Two-flop synchronisers for pins from the device
    logic [17:0] sync1, sync2;
    logic conf_n, mbox_n, mbox_d;
    logic [15:0] din;

    // Pin inputs pass two flops before use
    always_ff @(posedge ref_clk_i)
    begin
        sync1 <= {conflict_flag_n_i, mailbox_irq_n_i, mem_data_i};
        sync2 <= sync1;
        mbox_d <= sync2[16];
    end
    assign conf_n = sync2[17];
    assign mbox_n = sync2[16];
    assign din = sync2[15:0];

    // Sequencer and register file next-state
    always_comb
    begin
        logic ev_done;
        logic ev_conf;
        logic ev_mbox;
        logic [2:0] clr;
        ev_done = 1'b0;
        ev_conf = 1'b0;
        ev_mbox = mbox_d & ~mbox_n;
        clr = 3'h0;
        next_state = state;
        next_cnt = cnt;
        next_addr = addr;
        next_wdata = wdata;
        next_rdata = rdata;
        next_op_wr = op_wr;
        next_op_sem = op_sem;
        next_irq_mask = irq_mask;
        next_rd_q = rd_q;
        next_ack = 1'b0;
        next_conflict_seen = conflict_seen;
        if ((avs_read_i | avs_write_i) & ~ack)
        begin
            next_ack = 1'b1;
            if (avs_write_i)
            begin
                unique case (avs_address_i[3:2])
                    dpcm_pkg::IDX_CTRL:
                        if (avs_address_i[3] == 1'b0
                            && state == dpcm_pkg::S_IDLE
                            && avs_writedata_i[dpcm_pkg::CTRL_GO])
                        begin
                            next_op_wr = avs_writedata_i[dpcm_pkg::CTRL_WR];
                            next_op_sem = avs_writedata_i[dpcm_pkg::CTRL_SEM];
                            next_cnt = dpcm_pkg::APS_CYC;
                            next_conflict_seen = 1'b0;
                            next_state = dpcm_pkg::S_SETUP;
                        end
                    dpcm_pkg::IDX_ADDR: next_addr = avs_writedata_i[15:0];
                    dpcm_pkg::IDX_WDATA: next_wdata = avs_writedata_i[15:0];
                    dpcm_pkg::IDX_STATUS: clr = avs_writedata_i[2:0];
                endcase
            end
            else
            begin
                unique case (avs_address_i[3:2])
                    dpcm_pkg::IDX_CTRL: next_rd_q = {29'h0, op_sem, op_wr,
                        (state != dpcm_pkg::S_IDLE)};
                    dpcm_pkg::IDX_ADDR: next_rd_q = {16'h0, addr};
                    dpcm_pkg::IDX_WDATA: next_rd_q = {16'h0, rdata};
                    dpcm_pkg::IDX_STATUS: next_rd_q = {23'h0,
                        (state != dpcm_pkg::S_IDLE), 5'h0, irq_mask[2:0] &
                        3'h0 | irq_stat};
                endcase
            end
        end
        // Mask register shares the ctrl word upper half: bits 18:16
        if (avs_write_i & ~ack && avs_address_i[3:2] == dpcm_pkg::IDX_CTRL)
        begin
            next_irq_mask = avs_writedata_i[18:16];
        end
        unique case (state)
            dpcm_pkg::S_IDLE: ;
            // Address and enable settle before the strobe
            dpcm_pkg::S_SETUP:
                if (cnt != 4'h0)
                begin
                    next_cnt = cnt - 4'h1;
                end
                else
                begin
                    next_cnt = dpcm_pkg::ACCESS_CYC;
                    next_state = dpcm_pkg::S_STROBE;
                end
            // Strobe stays active while conflict flag is low
            dpcm_pkg::S_STROBE:
                if (!conf_n)
                begin
                    next_conflict_seen = 1'b1;
                    next_cnt = dpcm_pkg::ACCESS_CYC;
                end
                else if (cnt != 4'h0)
                begin
                    next_cnt = cnt - 4'h1;
                end
                else
                begin
                    next_cnt = conflict_seen ? dpcm_pkg::HOLD_CYC
                        : dpcm_pkg::DATA_CYC;
                    next_state = dpcm_pkg::S_HOLD;
                end
            dpcm_pkg::S_HOLD:
                if (cnt != 4'h0)
                begin
                    next_cnt = cnt - 4'h1;
                end
                else
                begin
                    next_rdata = din;
                    next_state = dpcm_pkg::S_DONE;
                end
            dpcm_pkg::S_DONE:
            begin
                ev_done = 1'b1;
                ev_conf = conflict_seen;
                next_state = dpcm_pkg::S_IDLE;
            end
        endcase
        // Set wins over write-one-to-clear
        next_irq_stat = (irq_stat & ~clr) | {ev_mbox, ev_conf, ev_done};
    end

    // Register the state
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            state <= dpcm_pkg::S_IDLE;
            cnt <= 4'h0;
            addr <= 16'h0000;
            wdata <= 16'h0000;
            rdata <= 16'h0000;
            op_wr <= 1'b0;
            op_sem <= 1'b0;
            irq_stat <= 3'h0;
            irq_mask <= 3'h0;
            rd_q <= 32'h0000_0000;
            ack <= 1'b0;
            conflict_seen <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            addr <= next_addr;
            wdata <= next_wdata;
            rdata <= next_rdata;
            op_wr <= next_op_wr;
            op_sem <= next_op_sem;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            rd_q <= next_rd_q;
            ack <= next_ack;
            conflict_seen <= next_conflict_seen;
        end
    end

    // Pin outputs registered from state; irq is the masked status, cleared by a status write
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            mem_addr_o <= 16'h0000;
            chip_enable_n_o <= 1'b1;
            semaphore_select_n_o <= 1'b1;
            rd_wr_n_o <= 1'b1;
            output_enable_n_o <= 1'b1;
            upper_lane_select_n_o <= 1'b1;
            lower_lane_select_n_o <= 1'b1;
            mem_data_o <= 16'h0000;
            mem_data_oe_n_o <= 1'b1;
            avs_readdata_o <= 32'h0000_0000;
            avs_waitrequest_o <= 1'b1;
            irq_o <= 1'b0;
        end
        else
        begin
            mem_addr_o <= next_addr;
            chip_enable_n_o <= (next_state == dpcm_pkg::S_IDLE) | next_op_sem;
            semaphore_select_n_o <= (next_state == dpcm_pkg::S_IDLE)
                | ~next_op_sem;
            rd_wr_n_o <= ~(next_op_wr & (next_state == dpcm_pkg::S_STROBE
                | next_state == dpcm_pkg::S_HOLD & next_conflict_seen));
            output_enable_n_o <= next_op_wr
                | (next_state == dpcm_pkg::S_IDLE);
            upper_lane_select_n_o <= (next_state == dpcm_pkg::S_IDLE);
            lower_lane_select_n_o <= (next_state == dpcm_pkg::S_IDLE);
            mem_data_o <= next_wdata;
            mem_data_oe_n_o <= ~(next_op_wr
                & (next_state != dpcm_pkg::S_IDLE));
            avs_readdata_o <= next_rd_q;
            avs_waitrequest_o <= ~next_ack;
            irq_o <= |(next_irq_stat & next_irq_mask);
        end
    end

    // Assertions
    chk_wait_one_cycle: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) (avs_read_i | avs_write_i) && !ack
        |=> !avs_waitrequest_o)
        else $error("waitrequest not released");
    chk_hold_after_conflict: assert property (
        @(posedge ref_clk_i)
        disable iff (reset_i) state == dpcm_pkg::S_STROBE && !conf_n
        |=> state == dpcm_pkg::S_STROBE)
        else $error("strobe released during conflict");
    chk_done_event: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) state == dpcm_pkg::S_DONE
        |=> irq_stat[dpcm_pkg::EV_DONE])
        else $error("done event lost");
    // A write held off by a conflict must still strobe in the hold phase
    chk_deferred_write: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        state == dpcm_pkg::S_HOLD && conflict_seen && op_wr |-> !rd_wr_n_o)
        else $error("deferred write strobe missing");
    chk_irq_level: assert property (
        @(posedge ref_clk_i) disable iff (reset_i)
        irq_o == |(irq_stat & irq_mask))
        else $error("irq output disagrees with status");
    cov_write: cover property (@(posedge ref_clk_i)
        state == dpcm_pkg::S_DONE && op_wr);
    cov_conflict: cover property (@(posedge ref_clk_i)
        state == dpcm_pkg::S_DONE && conflict_seen);
    cov_irq: cover property (@(posedge ref_clk_i) irq_o);
endmodule
`default_nettype wire

/* shared/dpcm_pkg.sv */
// Package of constants for the dual-port memory host controller
package dpcm_pkg;
    // Register byte offsets on the Avalon-MM slave
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_ADDR = 4'h4;
    localparam logic [3:0] OFS_WDATA = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hC;
    // Register indexes as decoded from word address
    localparam logic [1:0] IDX_CTRL = 2'h0;
    localparam logic [1:0] IDX_ADDR = 2'h1;
    localparam logic [1:0] IDX_WDATA = 2'h2;
    localparam logic [1:0] IDX_STATUS = 2'h3;
    localparam logic [1:0] IDX_IRQ = 2'h0;
    localparam logic [1:0] IDX_MASK = 2'h1;
    localparam logic [1:0] IDX_RDATA = 2'h2;
    // Control bits: go, write, semaphore
    localparam int CTRL_GO = 0;
    localparam int CTRL_WR = 1;
    localparam int CTRL_SEM = 2;
    // Status / event bit positions
    localparam int EV_DONE = 0;
    localparam int EV_CONFLICT = 1;
    localparam int EV_MAILBOX = 2;
    localparam int ST_BUSY = 8;
    // Mailbox addresses for each port
    localparam logic [15:0] MBOX_LEFT_WRITES = 16'hFFFF;
    localparam logic [15:0] MBOX_RIGHT_WRITES = 16'hFFFE;
    // Timing in ns and derived cycles at 10 MHz
    localparam int CLK_NS = 100;
    localparam int ACCESS_NS = 20;
    localparam int HOLD_NS = 15;
    localparam int APS_NS = 5;
    localparam int DATA_DELAY_NS = 45;
    localparam logic [3:0] ACCESS_CYC = 4'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] APS_CYC = 4'((APS_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] DATA_CYC =
        4'((DATA_DELAY_NS + CLK_NS - 1) / CLK_NS);
    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_SETUP = 5'h02,
        S_STROBE = 5'h04,
        S_HOLD = 5'h08,
        S_DONE = 5'h10
    } dpcm_state_t;
endpackage

/* verification/dpcm_port_model.sv */
// Behavioural model of one port of the dual-port memory device
`timescale 1ns/100ps
`default_nettype none
module dpcm_port_model (
    // Clock and scenario controls
    input wire logic ref_clk_i,
    input wire logic other_wins_i,
    input wire logic other_posts_i,
    // Port pins
    input wire logic [15:0] mem_addr_i,
    input wire logic chip_enable_n_i,
    input wire logic rd_wr_n_i,
    input wire logic output_enable_n_i,
    input wire logic [15:0] mem_data_i,
    output logic [15:0] mem_data_o,
    output logic conflict_flag_n_o,
    output logic mailbox_irq_n_o
);
    logic [15:0] mem [0:65535];
    logic [15:0] last = 16'h0000;
    logic reading;
    // Flag undefined at power-up: start it set so the host must clear it
    initial mailbox_irq_n_o = 1'b0;
    // The opposite port won arbitration while the scenario asks for it
    assign conflict_flag_n_o = !other_wins_i;
    assign reading = !chip_enable_n_i && !output_enable_n_i && rd_wr_n_i;
    // Idle bus shows the inverse of the last value, so stale data fails
    assign mem_data_o = reading ? mem[mem_addr_i] : ~last;
    // Array write and mailbox clear, both blocked while the conflict flag is low
    always @(posedge ref_clk_i)
    begin
        last <= mem_data_o;
        if (!chip_enable_n_i && !rd_wr_n_i && conflict_flag_n_o)
            mem[mem_addr_i] <= mem_data_i;
        if (other_posts_i)
            mailbox_irq_n_o <= 1'b0;
        else if (reading && conflict_flag_n_o && mem_addr_i == 16'hFFFE)
            mailbox_irq_n_o <= 1'b1;
    end
endmodule
`default_nettype wire

/* verification/dual_port_contention_mailbox_test.sv */
// Self-checking bench of the host controller against a port model
`timescale 1ns/100ps
`default_nettype none
module dual_port_contention_mailbox_test;
    logic ref_clk_i, reset_i, rd, wr, irq, wait_req, ce_n, rw_n, oe_n;
    logic other_wins, other_posts, conflict_n, mbox_n, data_oe_n;
    logic sem_n, ub_n, lb_n;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, q;
    logic [15:0] mem_addr, to_mem, from_mem;
    int failures = 0;
    int checks_done = 0;
    dpcm_host i_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wait_req), .irq_o(irq), .mem_addr_o(mem_addr),
        .chip_enable_n_o(ce_n), .rd_wr_n_o(rw_n), .output_enable_n_o(oe_n),
        .semaphore_select_n_o(sem_n), .upper_lane_select_n_o(ub_n),
        .lower_lane_select_n_o(lb_n), .mem_data_o(to_mem),
        .mem_data_oe_n_o(data_oe_n), .mem_data_i(from_mem),
        .conflict_flag_n_i(conflict_n), .mailbox_irq_n_i(mbox_n));
    dpcm_port_model i_model (.ref_clk_i(ref_clk_i), .other_wins_i(other_wins),
        .other_posts_i(other_posts), .mem_addr_i(mem_addr),
        .chip_enable_n_i(ce_n), .rd_wr_n_i(rw_n), .output_enable_n_i(oe_n),
        .mem_data_i(to_mem), .mem_data_o(from_mem),
        .conflict_flag_n_o(conflict_n), .mailbox_irq_n_o(mbox_n));
    // Clock at 10 MHz
    initial
    begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Avalon cycle held until waitrequest is sampled low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk_i);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        n = 0;
        do
        begin
            @(posedge ref_clk_i);
            n++;
        end
        while (wait_req !== 1'b0 && n < 100);
        // A slave that never answers counts as a mismatch
        if (wait_req !== 1'b0)
            failures++;
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // Start an access and poll the done bit; q holds the status at the end
    task run(input logic [15:0] a, input logic [15:0] d, input logic [31:0] c);
        int n;
        bus(1'b1, dpcm_pkg::OFS_STATUS, 32'h0000_0007);
        bus(1'b1, dpcm_pkg::OFS_ADDR, {16'h0000, a});
        bus(1'b1, dpcm_pkg::OFS_WDATA, {16'h0000, d});
        bus(1'b1, dpcm_pkg::OFS_CTRL, c);
        n = 0;
        do
        begin
            bus(1'b0, dpcm_pkg::OFS_STATUS, 32'h0000_0000);
            n++;
        end
        while (q[dpcm_pkg::EV_DONE] !== 1'b1 && n < 50);
        if (q[dpcm_pkg::EV_DONE] !== 1'b1)
            failures++;
    endtask
    task test_write_read;
        run(16'h1234, 16'hA5C3, 32'h0001_0003);
        repeat (2) @(posedge ref_clk_i);
        check(i_model.mem[16'h1234], 16'hA5C3);
        check(irq, 1'b1);
        bus(1'b1, dpcm_pkg::OFS_STATUS, 32'h0000_0001);
        repeat (2) @(posedge ref_clk_i);
        check(irq, 1'b0);
        run(16'h1234, 16'h0000, 32'h0001_0001);
        bus(1'b0, dpcm_pkg::OFS_WDATA, 32'h0000_0000);
        check(q[15:0], 16'hA5C3);
        $display("test_write_read done");
    endtask
    // Semaphore access: semaphore select low, chip enable high
    task test_semaphore;
        bus(1'b1, dpcm_pkg::OFS_STATUS, 32'h0000_0007);
        bus(1'b1, dpcm_pkg::OFS_ADDR, 32'h0000_0003);
        bus(1'b1, dpcm_pkg::OFS_CTRL, 32'h0000_0007);
        check(sem_n, 1'b0);
        check(ce_n, 1'b1);
        check({ub_n, lb_n}, 2'h0);
        repeat (8) @(posedge ref_clk_i);
        bus(1'b0, dpcm_pkg::OFS_STATUS, 32'h0000_0000);
        check(q[dpcm_pkg::EV_DONE], 1'b1);
        check(sem_n, 1'b1);
        $display("test_semaphore done");
    endtask
    // Opposite port holds the flag low before the strobe starts
    task test_conflict;
        other_wins <= 1'b1;
        bus(1'b1, dpcm_pkg::OFS_ADDR, 32'h0000_0010);
        bus(1'b1, dpcm_pkg::OFS_WDATA, 32'h0000_5555);
        bus(1'b1, dpcm_pkg::OFS_CTRL, 32'h0000_0003);
        repeat (8) @(posedge ref_clk_i);
        check(i_model.mem[16'h0010] === 16'h5555, 1'b0);
        check({ce_n, rw_n, data_oe_n}, 3'h0);
        other_wins <= 1'b0;
        repeat (12) @(posedge ref_clk_i);
        check(i_model.mem[16'h0010], 16'h5555);
        bus(1'b0, dpcm_pkg::OFS_STATUS, 32'h0000_0000);
        check(q[2:0], 3'h3);
        $display("test_conflict done");
    endtask
    // Mailbox flag is cleared by the host, posted, then cleared again
    task test_mailbox;
        run(dpcm_pkg::MBOX_RIGHT_WRITES, 16'h0000, 32'h0004_0001);
        check(mbox_n, 1'b1);
        bus(1'b1, dpcm_pkg::OFS_STATUS, 32'h0000_0007);
        other_posts <= 1'b1;
        @(posedge ref_clk_i);
        other_posts <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
        bus(1'b0, dpcm_pkg::OFS_STATUS, 32'h0000_0000);
        check(q[2], 1'b1);
        check(irq, 1'b1);
        run(dpcm_pkg::MBOX_RIGHT_WRITES, 16'h0000, 32'h0004_0001);
        check(mbox_n, 1'b1);
        $display("test_mailbox done");
    endtask
    task wrap_up;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        #(20000 * 100);
        failures++;
        wrap_up;
    end
    initial
    begin
        reset_i = 1'b1;
        {rd, wr, other_wins, other_posts} = 4'h0;
        addr = 4'h0;
        wdata = 32'h0000_0000;
        repeat (6) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        test_write_read;
        test_conflict;
        test_semaphore;
        test_mailbox;
        wrap_up;
    end
endmodule
`default_nettype wire
